// >>> pkg/ext_input_pkg.sv
// Constants and types for the extended control input block
package ext_input_pkg;
  // Ratios in hundredths of a percent
  localparam logic [15:0] OVERRIDE_RATIO_RST = 16'h2710;   // 100.00
  localparam logic [15:0] OVERRIDE_RATIO_MAX = 16'h4E20;   // 200.00
  localparam logic [15:0] LIMIT_RATIO_RST = 16'h0000;      // 0.00
  localparam logic [15:0] GAIN_RATIO_RST = 16'h1388;       // 50.00
  localparam logic [15:0] RATIO_FULL = 16'h2710;           // 100.00
  localparam logic [31:0] RATIO_DIV = 32'h0000_2710;
  // Velocity in milli-revolutions per second
  localparam logic [15:0] VEL_LIMIT = 16'h2710;            // 10.000 s^-1
  // Home return methods that use the proximity input
  localparam logic [2:0] METHOD_PROX_1 = 3'h1;
  localparam logic [2:0] METHOD_PROX_3 = 3'h3;
  localparam logic [2:0] METHOD_PROX_4 = 3'h4;
  localparam logic [2:0] METHOD_PROX_5 = 3'h5;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_RUN = 4'h2,
    ST_HOLD_PEND = 4'h4,
    ST_HELD = 4'h8
  } op_state_t;
endpackage

// >>> src/ext_input_ctrl.sv
// Extended control inputs: hold, override, integrator off, home return
// What this block does
// - Hold during internal motion decelerates at program rate and stops.
// - Hold is ignored during pulse train motion.
// - Hold during a program line write waits until the line is done.
// - While held, execution is suspended and busy stays closed.
// - Hold release resumes operation, re-accelerating if rotating.
// - Alarm or stop cancels hold, opens busy; release restarts nothing.
// - Start or motion command while held closes busy, stays held.
// - Override input scales programmed velocity by override ratio.
// - Without override input the programmed velocity is used.
// - Override velocity change uses the motion's own acc, dec, profile.
// - Overridden target velocity is clamped to 10 revolutions per second.
// - Integrator suppress at once limits integral part to limit ratio.
// - Integrator suppress scales proportional gain by reduction ratio.
// - No gain reduction while auto tuning runs.
// - Home return starts on rising start edge; falling edge ignored.
// - Absolute move after aborted home return raises origin warning.
// - Methods 1, 3, 4, 5 use the proximity input for home return.
module ext_input_ctrl (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic hold_request_input_i,
  input wire logic velocity_override_input_i,
  input wire logic integrator_suppress_input_i,
  input wire logic home_return_start_input_i,
  input wire logic home_proximity_input_i,
  input wire logic stop_input_i,
  input wire logic alarm_i,
  input wire logic servo_active_i,
  input wire logic pulse_train_mode_i,
  input wire logic param_write_active_i,
  input wire logic motion_start_i,
  input wire logic motion_absolute_i,
  input wire logic motion_done_i,
  input wire logic home_done_i,
  input wire logic auto_tuning_command_i,
  input wire logic [2:0] home_return_method_i,
  input wire logic [15:0] override_ratio_i,
  input wire logic [15:0] integral_limit_ratio_i,
  input wire logic [15:0] gain_reduction_ratio_i,
  input wire logic [15:0] move_velocity_i,
  output logic busy_o,
  output logic servo_active_output_o,
  output logic motion_hold_o,
  output logic home_start_o,
  output logic use_proximity_o,
  output logic near_home_o,
  output logic origin_undefined_warning_o,
  output logic [15:0] target_velocity_o,
  output logic [15:0] integral_ratio_o,
  output logic [15:0] prop_gain_ratio_o
);

  // Two-stage release of the asynchronous reset
  logic rst_s1_q;
  logic rst_n;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  // Scale a value by a ratio in hundredths of a percent
  function automatic logic [15:0] scale(input logic [15:0] v,
                                        input logic [15:0] r);
    logic [31:0] p;
    p = ({16'h0000, v} * {16'h0000, r}) / ext_input_pkg::RATIO_DIV;
    scale = (p > 32'h0000_FFFF) ? 16'hFFFF : p[15:0];
  endfunction

  // Home return methods that rely on the proximity sensor
  function automatic logic uses_proximity(input logic [2:0] m);
    uses_proximity = (m == ext_input_pkg::METHOD_PROX_1)
      || (m == ext_input_pkg::METHOD_PROX_3)
      || (m == ext_input_pkg::METHOD_PROX_4)
      || (m == ext_input_pkg::METHOD_PROX_5);
  endfunction

  // Input samples taken every control cycle
  logic hold_q;
  logic ovr_q;
  logic isup_q;
  logic hstart_q;
  logic hstart_prev_q;
  logic prox_q;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      hold_q <= 1'b0;
      ovr_q <= 1'b0;
      isup_q <= 1'b0;
      hstart_q <= 1'b0;
      hstart_prev_q <= 1'b0;
      prox_q <= 1'b0;
    end else begin
      hold_q <= hold_request_input_i;
      ovr_q <= velocity_override_input_i;
      isup_q <= integrator_suppress_input_i;
      hstart_q <= home_return_start_input_i;
      hstart_prev_q <= hstart_q;
      prox_q <= home_proximity_input_i;
    end
  end

  logic hstart_rise;
  logic cancel;
  // Only the rising edge counts; the falling edge does nothing
  assign hstart_rise = hstart_q && !hstart_prev_q;
  // Alarm or stop overrides everything, including the hold
  assign cancel = alarm_i || stop_input_i;

  // Operation state; pulse train motion never enters the held states
  // A hold that meets a program line write parks in the pending state,
  // so a half written line is never left behind in the program
  ext_input_pkg::op_state_t state_q;
  ext_input_pkg::op_state_t state_d;
  logic start_req;
  assign start_req = (motion_start_i || hstart_rise)
    && !pulse_train_mode_i;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ext_input_pkg::ST_IDLE: begin
        if (cancel) begin
          state_d = ext_input_pkg::ST_IDLE;
        end else if (start_req && hold_q) begin
          state_d = ext_input_pkg::ST_HELD;
        end else if (start_req) begin
          state_d = ext_input_pkg::ST_RUN;
        end
      end
      ext_input_pkg::ST_RUN: begin
        if (cancel || motion_done_i) begin
          state_d = ext_input_pkg::ST_IDLE;
        end else if (pulse_train_mode_i) begin
          state_d = ext_input_pkg::ST_RUN;
        end else if (hold_q && param_write_active_i) begin
          state_d = ext_input_pkg::ST_HOLD_PEND;
        end else if (hold_q) begin
          state_d = ext_input_pkg::ST_HELD;
        end
      end
      ext_input_pkg::ST_HOLD_PEND: begin
        if (cancel) begin
          state_d = ext_input_pkg::ST_IDLE;
        end else if (!hold_q) begin
          state_d = ext_input_pkg::ST_RUN;
        end else if (!param_write_active_i) begin
          state_d = ext_input_pkg::ST_HELD;
        end
      end
      ext_input_pkg::ST_HELD: begin
        if (cancel) begin
          state_d = ext_input_pkg::ST_IDLE;
        end else if (!hold_q) begin
          state_d = ext_input_pkg::ST_RUN;
        end
      end
      default: state_d = ext_input_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ext_input_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Busy closed whenever an operation exists, held or not
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= (state_d != ext_input_pkg::ST_IDLE);
    end
  end

  // Motion generator decelerates at the program rate while set
  // Taken from the next state so the ramp sees the hold a cycle sooner
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      motion_hold_o <= 1'b0;
    end else begin
      motion_hold_o <= (state_d == ext_input_pkg::ST_HELD);
    end
  end

  // Home start pulse; the method parameter picks the sequence downstream
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      home_start_o <= 1'b0;
    end else begin
      home_start_o <= hstart_rise && !cancel && !pulse_train_mode_i;
    end
  end

  // Methods that search with the proximity sensor
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      use_proximity_o <= 1'b0;
    end else begin
      use_proximity_o <= uses_proximity(home_return_method_i);
    end
  end

  // Proximity sample passed on to the home sequencer
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      near_home_o <= 1'b0;
    end else begin
      near_home_o <= prox_q;
    end
  end

  // Mirrors servo state so the controller can check it before home
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      servo_active_output_o <= 1'b0;
    end else begin
      servo_active_output_o <= servo_active_i;
    end
  end

  // Home tracking: an aborted home leaves the origin undefined
  // Only a completed home clears the abort; a new start does not
  logic homing_q;
  logic aborted_q;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      homing_q <= 1'b0;
      aborted_q <= 1'b0;
    end else begin
      if (home_start_o) begin
        homing_q <= 1'b1;
      end else if (home_done_i) begin
        homing_q <= 1'b0;
        aborted_q <= 1'b0;
      end else if (homing_q && cancel) begin
        homing_q <= 1'b0;
        aborted_q <= 1'b1;
      end
    end
  end

  // Warning stays until a home return completes
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      origin_undefined_warning_o <= 1'b0;
    end else if (aborted_q && motion_start_i && motion_absolute_i) begin
      origin_undefined_warning_o <= 1'b1;
    end else if (home_done_i) begin
      origin_undefined_warning_o <= 1'b0;
    end
  end

  // Override target; ramping uses the motion's own acc and dec profile
  // The product saturates at 16 bits before the clamp, so no wrap
  logic [15:0] ovr_ratio;
  logic [15:0] ovr_vel;
  assign ovr_ratio = (override_ratio_i > ext_input_pkg::OVERRIDE_RATIO_MAX)
    ? ext_input_pkg::OVERRIDE_RATIO_MAX : override_ratio_i;
  assign ovr_vel = scale(move_velocity_i, ovr_ratio);

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      target_velocity_o <= 16'h0000;
    end else if (ovr_q && !pulse_train_mode_i) begin
      // Clamp applies to overridden values only
      target_velocity_o <= (ovr_vel > ext_input_pkg::VEL_LIMIT)
        ? ext_input_pkg::VEL_LIMIT : ovr_vel;
    end else begin
      target_velocity_o <= move_velocity_i;
    end
  end

  // Integral part limited at once while the suppress input is on
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      integral_ratio_o <= ext_input_pkg::RATIO_FULL;
    end else begin
      integral_ratio_o <= isup_q ? integral_limit_ratio_i
        : ext_input_pkg::RATIO_FULL;
    end
  end

  // Gain cut skipped during tuning, which must see the real loop gain
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      prop_gain_ratio_o <= ext_input_pkg::RATIO_FULL;
    end else begin
      prop_gain_ratio_o <= (isup_q && !auto_tuning_command_i)
        ? gain_reduction_ratio_i : ext_input_pkg::RATIO_FULL;
    end
  end

endmodule

// >>> bench/ext_input_asserts.sv
// Assertion checker for the extended control input block
module ext_input_asserts (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic integrator_suppress_input_i,
  input wire logic auto_tuning_command_i,
  input wire logic [15:0] integral_limit_ratio_i,
  input wire logic [15:0] gain_reduction_ratio_i,
  input wire logic home_return_start_input_i,
  input wire logic stop_input_i,
  input wire logic [2:0] home_return_method_i,
  input wire logic velocity_override_input_i,
  input wire logic busy_o,
  input wire logic motion_hold_o,
  input wire logic home_start_o,
  input wire logic use_proximity_o,
  input wire logic [15:0] target_velocity_o,
  input wire logic [15:0] integral_ratio_o,
  input wire logic [15:0] prop_gain_ratio_o
);
  logic [2:0] up_q;
  logic warm;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // Count edges since release so $past never reaches into reset
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) up_q <= 3'h0;
    else if (up_q != 3'h7) up_q <= up_q + 3'h1;
  end
  assign warm = (up_q == 3'h7);
  sequence s_rise;
    !home_return_start_input_i ##1 home_return_start_input_i;
  endsequence
  sequence s_stop;
    stop_input_i [*3];
  endsequence
  a_gain_cut: assert property (warm && $past(integrator_suppress_input_i, 2)
    && !$past(auto_tuning_command_i) && $past(gain_reduction_ratio_i)
    == $past(gain_reduction_ratio_i, 2)
    |-> prop_gain_ratio_o == $past(gain_reduction_ratio_i, 2))
    else $error("gain ratio not reduced");
  a_gain_tune: assert property (warm && $past(auto_tuning_command_i)
    |-> prop_gain_ratio_o == ext_input_pkg::RATIO_FULL)
    else $error("gain reduced during tuning");
  a_integ_limit: assert property (warm && $past(integrator_suppress_input_i, 2)
    && $past(integral_limit_ratio_i) == $past(integral_limit_ratio_i, 2)
    |-> integral_ratio_o == $past(integral_limit_ratio_i, 2))
    else $error("integral ratio not limited");
  a_home_edge: assert property (s_rise ##2 1 |-> home_start_o)
    else $error("home start missed a rising edge");
  a_home_pulse: assert property (home_start_o |=> !home_start_o)
    else $error("home start longer than one cycle");
  a_stop_cancel: assert property (s_stop |=> !busy_o && !motion_hold_o)
    else $error("stop left the operation alive");
  a_hold_busy: assert property (motion_hold_o |-> busy_o)
    else $error("held without busy");
  a_prox_method: assert property (warm |-> use_proximity_o ==
    ($past(home_return_method_i) inside {3'h1, 3'h3, 3'h4, 3'h5}))
    else $error("proximity use wrong for method");
  a_vel_clamp: assert property (warm && $past(velocity_override_input_i, 2)
    |-> target_velocity_o <= ext_input_pkg::VEL_LIMIT)
    else $error("override velocity above limit");
endmodule
bind ext_input_ctrl ext_input_asserts ext_input_asserts_inst (.clk_i,
  .rst_b_i, .integrator_suppress_input_i, .auto_tuning_command_i,
  .integral_limit_ratio_i, .gain_reduction_ratio_i, .home_return_start_input_i,
  .stop_input_i, .home_return_method_i, .velocity_override_input_i, .busy_o,
  .motion_hold_o, .home_start_o, .use_proximity_o, .target_velocity_o,
  .integral_ratio_o, .prop_gain_ratio_o);

// >>> bench/master_model.sv
// Master controller model issuing home return start pulses
module master_model (
  input wire logic clk_i,
  input wire logic busy_i,
  input wire logic servo_on_i,
  input wire logic fault_i,
  output logic go_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial go_o = 1'b0;
  // Only an idle, servo-on, fault-free driver is asked to home
  task automatic home_pulse(output bit sent);
    sent = !busy_i && servo_on_i && !fault_i;
    if (sent) begin
      @(posedge clk_i) #1 go_o = 1'b1;
      repeat (2) @(posedge clk_i);
      #1 go_o = 1'b0;
    end
  endtask
endmodule

// >>> bench/tb.sv
// Self-checking bench for the extended control input block
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; \
  $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, rst_b_i, hold_request_input_i, velocity_override_input_i;
  logic integrator_suppress_input_i, home_return_start_input_i, stop_input_i;
  logic home_proximity_input_i, alarm_i, servo_active_i, pulse_train_mode_i;
  logic param_write_active_i, motion_start_i, motion_absolute_i;
  logic motion_done_i, home_done_i, auto_tuning_command_i, busy_o, sent;
  logic servo_active_output_o, motion_hold_o, home_start_o, use_proximity_o;
  logic near_home_o, origin_undefined_warning_o;
  logic [2:0] home_return_method_i;
  logic [15:0] override_ratio_i, integral_limit_ratio_i, gain_reduction_ratio_i;
  logic [15:0] move_velocity_i, target_velocity_o, integral_ratio_o;
  logic [15:0] prop_gain_ratio_o, vel;
  logic [49:0] notes[$];
  logic [49:0] e;
  logic look = 1'b0;
  logic [3:0] hits;
  logic [47:0] outs;
  assign outs = {target_velocity_o, integral_ratio_o, prop_gain_ratio_o};
  int failures = 0;
  int cmp_count = 0;
  int seed = 32'h5730;
  ext_input_ctrl ext_input_ctrl_inst (.clk_i, .rst_b_i, .hold_request_input_i,
    .velocity_override_input_i, .integrator_suppress_input_i,
    .home_return_start_input_i, .home_proximity_input_i, .stop_input_i,
    .alarm_i, .servo_active_i, .pulse_train_mode_i, .param_write_active_i,
    .motion_start_i, .motion_absolute_i, .motion_done_i, .home_done_i,
    .auto_tuning_command_i, .home_return_method_i, .override_ratio_i,
    .integral_limit_ratio_i, .gain_reduction_ratio_i, .move_velocity_i,
    .busy_o, .servo_active_output_o, .motion_hold_o, .home_start_o,
    .use_proximity_o, .near_home_o, .origin_undefined_warning_o,
    .target_velocity_o, .integral_ratio_o, .prop_gain_ratio_o);
  master_model master_model_inst (.clk_i, .busy_i(busy_o),
    .servo_on_i(servo_active_output_o), .fault_i(stop_input_i || alarm_i),
    .go_o(home_return_start_input_i));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic close_out;
    $display("compares %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Queue the expectation, then let three edges pass before the look
  task automatic note(input logic [49:0] x);
    notes.push_back(x);
    repeat (3) @(posedge clk_i);
    #1 look = 1'b1;
    @(posedge clk_i) #1 look = 1'b0;
  endtask
  // Bit 49 picks the busy/hold pair, else the velocity and ratios
  // Looked at on the falling edge, well clear of the launching edge
  always @(negedge clk_i) begin
    if (look && notes.size() > 0) begin
      e = notes.pop_front();
      if (e[49]) begin
        `CHK({busy_o, motion_hold_o}, e[1:0])
      end else begin
        `CHK(outs, e[47:0])
      end
    end
  end
  initial begin
    #50000 failures++;
    close_out();
  end
  initial begin
    {hold_request_input_i, velocity_override_input_i, stop_input_i} = 3'h0;
    {integrator_suppress_input_i, home_proximity_input_i, alarm_i} = 3'h0;
    {pulse_train_mode_i, param_write_active_i, motion_start_i} = 3'h0;
    {motion_absolute_i, motion_done_i, home_done_i} = 3'h0;
    auto_tuning_command_i = 1'b0;
    servo_active_i = 1'b1;
    home_return_method_i = 3'h0;
    override_ratio_i = ext_input_pkg::OVERRIDE_RATIO_RST;
    integral_limit_ratio_i = ext_input_pkg::LIMIT_RATIO_RST;
    gain_reduction_ratio_i = ext_input_pkg::GAIN_RATIO_RST;
    move_velocity_i = 16'h0000;
    rst_b_i = 1'b0;
    repeat (10) @(posedge clk_i);
    #1 rst_b_i = 1'b1;
    repeat (3) @(posedge clk_i);
    #1 motion_start_i = 1'b1;
    @(posedge clk_i) #1 motion_start_i = 1'b0;
    // Random ratios and velocities on a running move; first is 2.000 at 150%
    for (int i = 0; i < 12; i++) begin
      move_velocity_i = (i == 0) ? 16'h07D0 : 16'($random(seed));
      override_ratio_i = (i == 0) ? 16'h3A98 : 16'($unsigned($random(seed)) % 20001);
      integral_limit_ratio_i = 16'($unsigned($random(seed)) % 10001);
      gain_reduction_ratio_i = 16'($unsigned($random(seed)) % 10001);
      {velocity_override_input_i, integrator_suppress_input_i,
        auto_tuning_command_i, home_proximity_input_i} = 4'($random(seed));
      if (i == 0) velocity_override_input_i = 1'b1;
      vel = 16'(velocity_override_input_i ? (32'(move_velocity_i)
        * override_ratio_i / 32'h0000_2710) : move_velocity_i);
      if (velocity_override_input_i && (32'(move_velocity_i) * override_ratio_i
        / 32'h0000_2710) > ext_input_pkg::VEL_LIMIT) vel = ext_input_pkg::VEL_LIMIT;
      note({2'h0, vel, integrator_suppress_input_i ? integral_limit_ratio_i
        : ext_input_pkg::RATIO_FULL, (integrator_suppress_input_i &&
        !auto_tuning_command_i) ? gain_reduction_ratio_i : ext_input_pkg::RATIO_FULL});
    end
    $display("override and gain test done");
    {velocity_override_input_i, integrator_suppress_input_i} = 2'h0;
    auto_tuning_command_i = 1'b0;
    // Hold under pulse train, then held, start while held, stop, release
    pulse_train_mode_i = 1'b1;
    hold_request_input_i = 1'b1;
    note({1'b1, 47'h0, 2'h2});
    pulse_train_mode_i = 1'b0;
    note({1'b1, 47'h0, 2'h3});
    motion_start_i = 1'b1;
    @(posedge clk_i) #1 motion_start_i = 1'b0;
    note({1'b1, 47'h0, 2'h3});
    stop_input_i = 1'b1;
    note({1'b1, 47'h0, 2'h0});
    hold_request_input_i = 1'b0;
    note({1'b1, 47'h0, 2'h0});
    stop_input_i = 1'b0;
    // Hold during a line write waits, then holds, then resumes
    param_write_active_i = 1'b1;
    motion_start_i = 1'b1;
    @(posedge clk_i) #1 motion_start_i = 1'b0;
    hold_request_input_i = 1'b1;
    note({1'b1, 47'h0, 2'h2});
    param_write_active_i = 1'b0;
    note({1'b1, 47'h0, 2'h3});
    hold_request_input_i = 1'b0;
    note({1'b1, 47'h0, 2'h2});
    motion_done_i = 1'b1;
    @(posedge clk_i) #1 motion_done_i = 1'b0;
    note({1'b1, 47'h0, 2'h0});
    $display("hold test done");
    // One home start per rising edge; methods swept for proximity use
    home_return_method_i = 3'h3;
    repeat (3) @(posedge clk_i);
    master_model_inst.home_pulse(sent);
    hits = 4'h0;
    repeat (10) @(posedge clk_i) hits += 4'(home_start_o);
    `CHK(hits, 4'h1)
    `CHK(busy_o, 1'b1)
    `CHK(sent, 1'b1)
    `CHK(servo_active_output_o, 1'b1)
    for (int m = 0; m < 8; m++) begin
      #1 home_return_method_i = 3'(m);
      home_proximity_input_i = m[0];
      repeat (3) @(posedge clk_i);
      `CHK(use_proximity_o, 1'(m inside {1, 3, 4, 5}))
      `CHK(near_home_o, 1'(m[0]))
    end
    // Abort the running home by stop, then ask for an absolute move
    #1 stop_input_i = 1'b1;
    @(posedge clk_i) #1 stop_input_i = 1'b0;
    motion_absolute_i = 1'b1;
    motion_start_i = 1'b1;
    @(posedge clk_i) #1 motion_start_i = 1'b0;
    motion_absolute_i = 1'b0;
    repeat (2) @(posedge clk_i);
    `CHK(origin_undefined_warning_o, 1'b1)
    #1 home_done_i = 1'b1;
    @(posedge clk_i) #1 home_done_i = 1'b0;
    @(posedge clk_i);
    `CHK(origin_undefined_warning_o, 1'b0)
    $display("home start test done");
    close_out();
  end
endmodule
